//--- rtl/dc_brake_pkg.sv
package dc_brake_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 6;
   localparam int          DATA_W        = 32;
   localparam logic [5:0]  OFS_CTRL      = 6'h00;
   localparam logic [5:0]  OFS_CFG       = 6'h04;
   localparam logic [5:0]  OFS_DELAY     = 6'h08;
   localparam logic [5:0]  OFS_DURATION  = 6'h0c;
   localparam logic [5:0]  OFS_LEVEL     = 6'h10;
   localparam logic [5:0]  OFS_FULL_LOAD = 6'h14;
   localparam logic [5:0]  OFS_STATE     = 6'h18;
   localparam logic [5:0]  OFS_IRQ_STAT  = 6'h1c;
   localparam logic [5:0]  OFS_IRQ_MASK  = 6'h20;
   localparam logic [5:0]  OFS_STARTS    = 6'h24;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_DC_MODE_BIT   = 0;
   localparam int CTRL_EN_ASSIGN_BIT = 1;
   localparam int CTRL_DIS_ASSIGN_BIT= 2;
   localparam int CTRL_RELAY_BIT     = 3;
   localparam int CTRL_W             = 4;
   localparam int CFG_HEAVY_BIT      = 0;
   localparam int CFG_HALL_BIT       = 1;
   localparam int IRQ_START_BIT      = 0;
   localparam int IRQ_DONE_BIT       = 1;
   localparam int IRQ_ABORT_BIT      = 2;
   localparam int IRQ_W              = 3;
   localparam int LEVEL_W            = 9;
   localparam int FULL_LOAD_W        = 11;
   localparam int MS_W               = 16;

   // ----------------------------------------------------------------
   // reset values and limits
   // ----------------------------------------------------------------
   localparam logic [3:0]  CTRL_RST      = 4'h0;
   localparam logic [15:0] DELAY_RST     = 16'h0064;
   localparam logic [15:0] DURATION_RST  = 16'h03e8;
   localparam logic [8:0]  LEVEL_RST     = 9'h0c8;
   localparam logic [10:0] FULL_LOAD_RST = 11'h00a;
   localparam logic [8:0]  STD_LIMIT_PCT = 9'h0fa;
   localparam logic [8:0]  HVY_LIMIT_PCT = 9'h190;

   // ----------------------------------------------------------------
   // timing: 1 ms tick, post-brake hold table (amps, ms)
   // ----------------------------------------------------------------
   localparam int CLK_HZ      = 40_000_000;
   localparam int TICK_MS     = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int PRESCALE_W  = 16;
   localparam int HOLD_A_AMP  = 10;
   localparam int HOLD_B_AMP  = 100;
   localparam int HOLD_C_AMP  = 500;
   localparam int HOLD_D_AMP  = 1000;
   localparam int HOLD_A_MS   = 400;
   localparam int HOLD_B_MS   = 800;
   localparam int HOLD_C_MS   = 2300;
   localparam int HOLD_D_MS   = 4300;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DELAY = 2'b01,
      ST_BRAKE = 2'b10,
      ST_HOLD  = 2'b11
   } brake_state_type;

   typedef struct packed {
      logic [5:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_type;

   typedef struct packed {
      logic running_sel;
      logic heavy;
      logic hall;
   } overload_ctl_type;

endpackage

//--- rtl/dc_brake_sequencer.sv
`timescale 1ns/1ps

// Overview of operation
// - in dc-brake stop mode with the braking relay assigned, a stop command starts DC current injection.
// - standard duty limits brake level to 250% of full load current.
// - heavy duty allows up to 400% of full load current.
// - heavy duty counts each braked stop as one extra start.
// - the assigned braking relay is energised during braking.
// - relay stays energised for a hold period after brake time.
// - hold grows with full load: 0.4/0.8/2.3/4.3 s at 10/100/500/1000 A.
// - overload protection stays active, using running setting while braking.
// - overload calculation follows duty class and feedback source.
// - with brake enable assigned, brake only while input energised.
// - with brake disable assigned, brake unless input energised.
// - after input-caused end, no resume that stop; go idle.
// - duty class and feedback source are fixed straps, not runtime.
// - programmable delay between stop command and DC current.
// - DC current applied for programmable brake duration, then removed.
// - DC current regulated to programmable brake level.
module dc_brake_sequencer #(
   parameter int unsigned TICK_CYCLES = dc_brake_pkg::TICK_CYCLES
) (
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_reset,
   input  wire dc_brake_pkg::reg_req_type     i_req,
   output logic [31:0]                        o_rdata,
   input  wire logic                          i_stop_cmd,
   input  wire logic                          i_brake_en_in,
   input  wire logic                          i_brake_dis_in,
   input  wire logic                          i_heavy_duty_strap,
   input  wire logic                          i_hall_strap,
   output logic                               o_brake_relay,
   output logic                               o_dc_inject,
   output logic [8:0]                         o_brake_level_pct,
   output logic                               o_extra_start,
   output dc_brake_pkg::overload_ctl_type     o_overload_ctl,
   output logic                               o_irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      dc_brake_pkg::brake_state_type state;
      logic [15:0] prescale;
      logic [15:0] ms_cnt;
      logic        strap_taken;
      logic        heavy;
      logic        hall;
      logic [3:0]  ctrl;
      logic [15:0] delay_ms;
      logic [15:0] dur_ms;
      logic [8:0]  level;
      logic [10:0] full_load;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      logic [15:0] starts;
      logic [31:0] rdata;
      logic        irq;
      logic        relay;
      logic        dc;
      logic [8:0]  level_out;
      logic        extra_start;
      logic        ol_running;
   } seq_state_type;

   localparam seq_state_type STATE_RST = '{
      state     : dc_brake_pkg::ST_IDLE,
      ctrl      : dc_brake_pkg::CTRL_RST,
      delay_ms  : dc_brake_pkg::DELAY_RST,
      dur_ms    : dc_brake_pkg::DURATION_RST,
      level     : dc_brake_pkg::LEVEL_RST,
      full_load : dc_brake_pkg::FULL_LOAD_RST,
      default   : '0
   };

   seq_state_type seq_reg;
   seq_state_type seq_next;

   // ----------------------------------------------------------------
   // post-brake hold from full load current, piecewise linear
   // ----------------------------------------------------------------
   function automatic logic [15:0] hold_ms_of(input logic [10:0] amps);
      int a;
      int ms;
      a = int'(amps);
      if (a <= dc_brake_pkg::HOLD_A_AMP) begin
         ms = dc_brake_pkg::HOLD_A_MS;
      end else if (a <= dc_brake_pkg::HOLD_B_AMP) begin
         ms = dc_brake_pkg::HOLD_A_MS + (a - dc_brake_pkg::HOLD_A_AMP)
              * (dc_brake_pkg::HOLD_B_MS - dc_brake_pkg::HOLD_A_MS)
              / (dc_brake_pkg::HOLD_B_AMP - dc_brake_pkg::HOLD_A_AMP);
      end else if (a <= dc_brake_pkg::HOLD_C_AMP) begin
         ms = dc_brake_pkg::HOLD_B_MS + (a - dc_brake_pkg::HOLD_B_AMP)
              * (dc_brake_pkg::HOLD_C_MS - dc_brake_pkg::HOLD_B_MS)
              / (dc_brake_pkg::HOLD_C_AMP - dc_brake_pkg::HOLD_B_AMP);
      end else begin
         ms = dc_brake_pkg::HOLD_C_MS + (a - dc_brake_pkg::HOLD_C_AMP)
              * (dc_brake_pkg::HOLD_D_MS - dc_brake_pkg::HOLD_C_MS)
              / (dc_brake_pkg::HOLD_D_AMP - dc_brake_pkg::HOLD_C_AMP);
      end
      return ms[15:0];
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic        tick;
   logic        permit;
   logic        expired;
   logic [8:0]  limit;
   logic [8:0]  level_clamped;
   logic [15:0] target_ms;
   logic [2:0]  events;
   logic [2:0]  irq_clr;

   always_comb begin
      seq_next = seq_reg;
      events   = 3'h0;
      irq_clr  = 3'h0;
      seq_next.extra_start = 1'b0;

      // straps caught once after reset release
      if (!seq_reg.strap_taken) begin
         seq_next.strap_taken = 1'b1;
         seq_next.heavy       = i_heavy_duty_strap;
         seq_next.hall        = i_hall_strap;
      end

      tick = (seq_reg.prescale == 16'(TICK_CYCLES - 1));
      seq_next.prescale = tick ? 16'h0000 : seq_reg.prescale + 16'h0001;
      if (tick) begin
         seq_next.ms_cnt = seq_reg.ms_cnt + 16'h0001;
      end

      permit = (!seq_reg.ctrl[dc_brake_pkg::CTRL_EN_ASSIGN_BIT] | i_brake_en_in)
             & (!seq_reg.ctrl[dc_brake_pkg::CTRL_DIS_ASSIGN_BIT] | !i_brake_dis_in);
      limit = seq_reg.heavy ? dc_brake_pkg::HVY_LIMIT_PCT : dc_brake_pkg::STD_LIMIT_PCT;
      level_clamped = (seq_reg.level > limit) ? limit : seq_reg.level;

      case (seq_reg.state)
         dc_brake_pkg::ST_DELAY: target_ms = seq_reg.delay_ms;
         dc_brake_pkg::ST_BRAKE: target_ms = seq_reg.dur_ms;
         default:                target_ms = hold_ms_of(seq_reg.full_load);
      endcase
      expired = (seq_reg.ms_cnt >= target_ms);

      case (seq_reg.state)
         dc_brake_pkg::ST_IDLE: begin
            if (i_stop_cmd && permit
                && seq_reg.ctrl[dc_brake_pkg::CTRL_DC_MODE_BIT]
                && seq_reg.ctrl[dc_brake_pkg::CTRL_RELAY_BIT]) begin
               seq_next.state = dc_brake_pkg::ST_DELAY;
            end
         end
         dc_brake_pkg::ST_DELAY: begin
            if (!permit) begin
               seq_next.state = dc_brake_pkg::ST_IDLE;
               events[dc_brake_pkg::IRQ_ABORT_BIT] = 1'b1;
            end else if (expired) begin
               seq_next.state = dc_brake_pkg::ST_BRAKE;
               seq_next.extra_start = seq_reg.heavy;
               if (seq_reg.heavy) begin
                  seq_next.starts = seq_reg.starts + 16'h0001;
               end
               events[dc_brake_pkg::IRQ_START_BIT] = 1'b1;
            end
         end
         dc_brake_pkg::ST_BRAKE: begin
            if (!permit) begin
               seq_next.state = dc_brake_pkg::ST_IDLE;
               events[dc_brake_pkg::IRQ_ABORT_BIT] = 1'b1;
            end else if (expired) begin
               seq_next.state = dc_brake_pkg::ST_HOLD;
            end
         end
         default: begin
            if (expired) begin
               seq_next.state = dc_brake_pkg::ST_IDLE;
               events[dc_brake_pkg::IRQ_DONE_BIT] = 1'b1;
            end
         end
      endcase

      // timers restart on every state change
      if (seq_next.state != seq_reg.state) begin
         seq_next.prescale = 16'h0000;
         seq_next.ms_cnt   = 16'h0000;
      end

      seq_next.relay      = (seq_next.state != dc_brake_pkg::ST_IDLE);
      seq_next.dc         = (seq_next.state == dc_brake_pkg::ST_BRAKE);
      seq_next.level_out  = seq_next.dc ? level_clamped : 9'h000;
      seq_next.ol_running = seq_next.relay;

      // register writes
      if (i_req.wr) begin
         if (i_req.addr == dc_brake_pkg::OFS_CTRL) begin
            seq_next.ctrl = i_req.wdata[3:0];
         end else if (i_req.addr == dc_brake_pkg::OFS_DELAY) begin
            seq_next.delay_ms = i_req.wdata[15:0];
         end else if (i_req.addr == dc_brake_pkg::OFS_DURATION) begin
            seq_next.dur_ms = i_req.wdata[15:0];
         end else if (i_req.addr == dc_brake_pkg::OFS_LEVEL) begin
            seq_next.level = i_req.wdata[8:0];
         end else if (i_req.addr == dc_brake_pkg::OFS_FULL_LOAD) begin
            seq_next.full_load = i_req.wdata[10:0];
         end else if (i_req.addr == dc_brake_pkg::OFS_IRQ_STAT) begin
            irq_clr = i_req.wdata[2:0];
         end else if (i_req.addr == dc_brake_pkg::OFS_IRQ_MASK) begin
            seq_next.irq_mask = i_req.wdata[2:0];
         end
      end

      // set wins over clear
      seq_next.irq_stat = (seq_reg.irq_stat & ~irq_clr) | events;
      seq_next.irq      = |(seq_next.irq_stat & seq_next.irq_mask);

      // register reads, data valid the following cycle only
      seq_next.rdata = 32'h0000_0000;
      if (i_req.rd) begin
         if (i_req.addr == dc_brake_pkg::OFS_CTRL) begin
            seq_next.rdata = {28'h0000000, seq_reg.ctrl};
         end else if (i_req.addr == dc_brake_pkg::OFS_CFG) begin
            seq_next.rdata = {30'h00000000, seq_reg.hall, seq_reg.heavy};
         end else if (i_req.addr == dc_brake_pkg::OFS_DELAY) begin
            seq_next.rdata = {16'h0000, seq_reg.delay_ms};
         end else if (i_req.addr == dc_brake_pkg::OFS_DURATION) begin
            seq_next.rdata = {16'h0000, seq_reg.dur_ms};
         end else if (i_req.addr == dc_brake_pkg::OFS_LEVEL) begin
            seq_next.rdata = {23'h000000, seq_reg.level};
         end else if (i_req.addr == dc_brake_pkg::OFS_FULL_LOAD) begin
            seq_next.rdata = {21'h000000, seq_reg.full_load};
         end else if (i_req.addr == dc_brake_pkg::OFS_STATE) begin
            seq_next.rdata = {seq_reg.ms_cnt, 12'h000, seq_reg.dc, seq_reg.relay, seq_reg.state};
         end else if (i_req.addr == dc_brake_pkg::OFS_IRQ_STAT) begin
            seq_next.rdata = {29'h00000000, seq_reg.irq_stat};
         end else if (i_req.addr == dc_brake_pkg::OFS_IRQ_MASK) begin
            seq_next.rdata = {29'h00000000, seq_reg.irq_mask};
         end else if (i_req.addr == dc_brake_pkg::OFS_STARTS) begin
            seq_next.rdata = {16'h0000, seq_reg.starts};
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         seq_reg <= STATE_RST;
      end else begin
         seq_reg <= seq_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_rdata                    = seq_reg.rdata;
   assign o_brake_relay              = seq_reg.relay;
   assign o_dc_inject                = seq_reg.dc;
   assign o_brake_level_pct          = seq_reg.level_out;
   assign o_extra_start              = seq_reg.extra_start;
   assign o_overload_ctl             = {seq_reg.ol_running, seq_reg.heavy, seq_reg.hall};
   assign o_irq                      = seq_reg.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   stop_starts_delay_a: assert property (
      (seq_reg.state == dc_brake_pkg::ST_IDLE && i_stop_cmd && permit
       && seq_reg.ctrl[dc_brake_pkg::CTRL_DC_MODE_BIT] && seq_reg.ctrl[dc_brake_pkg::CTRL_RELAY_BIT])
      |=> (seq_reg.state == dc_brake_pkg::ST_DELAY) && o_brake_relay && !o_dc_inject)
      else $error("stop command did not start brake delay");

   level_limit_a: assert property (
      o_dc_inject |-> (o_brake_level_pct
                       <= (seq_reg.heavy ? dc_brake_pkg::HVY_LIMIT_PCT : dc_brake_pkg::STD_LIMIT_PCT)))
      else $error("brake level above duty limit");

   extra_start_a: assert property (
      $rose(o_dc_inject) |-> (o_extra_start == seq_reg.heavy) && (seq_reg.starts == $past(seq_reg.starts)
      + {15'h0000, seq_reg.heavy}))
      else $error("heavy braked stop not counted as start");

   relay_covers_dc_a: assert property (
      o_dc_inject |-> o_brake_relay ##1 (o_dc_inject || o_brake_relay || seq_reg.state == dc_brake_pkg::ST_IDLE))
      else $error("dc applied without braking relay");

   hold_relay_a: assert property (
      ($fell(o_dc_inject) && seq_reg.state == dc_brake_pkg::ST_HOLD)
      |-> o_brake_relay [*8])
      else $error("relay dropped before hold period");

   enable_drop_a: assert property (
      (seq_reg.ctrl[dc_brake_pkg::CTRL_EN_ASSIGN_BIT] && !i_brake_en_in && o_brake_relay
       && seq_reg.state != dc_brake_pkg::ST_HOLD)
      |=> !o_dc_inject && seq_reg.state == dc_brake_pkg::ST_IDLE)
      else $error("braking continued after enable dropped");

   disable_set_a: assert property (
      (seq_reg.ctrl[dc_brake_pkg::CTRL_DIS_ASSIGN_BIT] && i_brake_dis_in && o_brake_relay
       && seq_reg.state != dc_brake_pkg::ST_HOLD)
      |=> !o_dc_inject ##1 !o_dc_inject)
      else $error("braking continued after disable set");

   overload_running_a: assert property (
      o_brake_relay |-> o_overload_ctl.running_sel)
      else $error("running overload setting not used while braking");

   irq_level_a: assert property (
      o_irq == |(seq_reg.irq_stat & seq_reg.irq_mask))
      else $error("interrupt output disagrees with status and mask");

   read_idle_a: assert property (
      !i_req.rd |=> o_rdata == 32'h0000_0000)
      else $error("read data present without read strobe");

endmodule // dc_brake_sequencer

//--- test/motor_stage_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// power stage, braking contactor and digital inputs
// ----------------------------------------------------------------
module motor_stage_model #(
   parameter int CLOSE_CYC      = 2,
   parameter int ANALOG_SPAN_MV = 10000  // hall feedback input range, 0 to 10 V
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_brake_relay,
   input  wire logic        i_dc_inject,
   input  wire logic        i_en_level,
   input  wire logic        i_dis_level,
   output logic             o_brake_en_in,
   output logic             o_brake_dis_in,
   output logic [15:0]      o_dc_open_cnt
);
   int close_cnt;
   logic contactor_closed;

   // contactor pulls in late, drops at once
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         close_cnt        <= 0;
         contactor_closed <= 1'b0;
      end else if (!i_brake_relay) begin
         close_cnt        <= 0;
         contactor_closed <= 1'b0;
      end else if (close_cnt < CLOSE_CYC) begin
         close_cnt <= close_cnt + 1;
      end else begin
         contactor_closed <= 1'b1;
      end
   end

   // dc current without a closed path damages the stage
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_dc_open_cnt <= 16'h0000;
      end else if (i_dc_inject && !contactor_closed) begin
         o_dc_open_cnt <= o_dc_open_cnt + 16'h0001;
      end
   end

   // digital inputs follow the operator one clock later
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_brake_en_in  <= 1'b0;
         o_brake_dis_in <= 1'b0;
      end else begin
         o_brake_en_in  <= i_en_level;
         o_brake_dis_in <= i_dis_level;
      end
   end
endmodule // motor_stage_model

//--- test/tb.sv
`timescale 1ns/1ps

module tb;
   localparam int TICK = 4;
   logic                           ref_clk, reset, stop_cmd, heavy_strap, hall_strap;
   logic                           en_req, dis_req, brake_en, brake_dis, relay, dc, extra, irq;
   dc_brake_pkg::reg_req_type      req;
   dc_brake_pkg::overload_ctl_type ol_ctl;
   logic [31:0]                    rdata;
   logic [8:0]                     level;
   logic [15:0]                    dc_open_cnt;
   int                             err_count, samples_checked;

   dc_brake_sequencer #(.TICK_CYCLES(TICK)) dut (
      .i_ref_clk(ref_clk), .i_reset(reset), .i_req(req), .o_rdata(rdata), .i_stop_cmd(stop_cmd),
      .i_brake_en_in(brake_en), .i_brake_dis_in(brake_dis), .i_heavy_duty_strap(heavy_strap),
      .i_hall_strap(hall_strap), .o_brake_relay(relay), .o_dc_inject(dc), .o_brake_level_pct(level),
      .o_extra_start(extra), .o_overload_ctl(ol_ctl), .o_irq(irq));

   motor_stage_model plant (
      .i_ref_clk(ref_clk), .i_reset(reset), .i_brake_relay(relay), .i_dc_inject(dc),
      .i_en_level(en_req), .i_dis_level(dis_req), .o_brake_en_in(brake_en),
      .o_brake_dis_in(brake_dis), .o_dc_open_cnt(dc_open_cnt));

   // ----------------------------------------------------------------
   // clock, reset, bus and checking tasks
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic do_reset(input logic heavy, input logic hall);
      reset <= 1'b1;
      heavy_strap <= heavy;
      hall_strap <= hall;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic pulse_stop();
      @(posedge ref_clk);
      stop_cmd <= 1'b1;
      @(posedge ref_clk);
      stop_cmd <= 1'b0;
      #1;
   endtask

   // one stop; counts relay, dc, extra-start and overload-select slips
   task automatic run_stop(output int n_dc, n_rel, n_xs, n_ol, output logic [8:0] lvl);
      int guard;
      n_dc = 0; n_rel = 0; n_xs = 0; n_ol = 0; lvl = '0; guard = 0;
      pulse_stop();
      while (relay === 1'b1 && guard < 20000) begin
         n_rel++;
         if (dc === 1'b1) begin n_dc++; lvl = level; end
         if (extra === 1'b1) n_xs++;
         if (ol_ctl.running_sel !== 1'b1) n_ol++;
         guard++;
         @(posedge ref_clk); #1;
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_reset_values();
      logic [5:0]  adr [8] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h20, 6'h3c};
      logic [31:0] exv [8] = '{32'h0, 32'h0, 32'h64, 32'h3e8, 32'hc8, 32'ha, 32'h0, 32'h0};
      logic [31:0] d;
      wr_reg(dc_brake_pkg::OFS_CFG, 32'h3);
      wr_reg(6'h3c, 32'hffff_ffff);
      foreach (adr[i]) begin
         rd_reg(adr[i], d);
         check("reset value", d, exv[i]);
      end
      @(posedge ref_clk); #1;
      check("read data after slot", rdata, 32'h0);
      $display("test reset_values finished");
   endtask

   task automatic test_std_hold();
      int fl [4] = '{10, 100, 500, 1000};
      int hold [4] = '{400, 800, 2300, 4300};
      int n_dc, n_rel, n_xs, n_ol;
      logic [8:0] lvl;
      logic [31:0] d;
      wr_reg(dc_brake_pkg::OFS_CTRL, 32'h8);
      run_stop(n_dc, n_rel, n_xs, n_ol, lvl);
      check("stop mode off", n_rel, 0);
      wr_reg(dc_brake_pkg::OFS_CTRL, 32'h1);
      run_stop(n_dc, n_rel, n_xs, n_ol, lvl);
      check("no relay assigned", n_rel, 0);
      wr_reg(dc_brake_pkg::OFS_CTRL, 32'h9);
      wr_reg(dc_brake_pkg::OFS_DELAY, 32'h1);
      wr_reg(dc_brake_pkg::OFS_DURATION, 32'h2);
      wr_reg(dc_brake_pkg::OFS_LEVEL, 32'h12c);
      wr_reg(dc_brake_pkg::OFS_IRQ_MASK, 32'h2);
      foreach (fl[i]) begin
         wr_reg(dc_brake_pkg::OFS_FULL_LOAD, fl[i]);
         run_stop(n_dc, n_rel, n_xs, n_ol, lvl);
         check("dc cycles", n_dc, 2 * TICK + 1);
         check("relay cycles", n_rel, (TICK + 1) + (2 * TICK + 1) + (hold[i] * TICK + 1));
         check("level clamp", lvl, 9'h0fa);
         check("extra start", n_xs, 0);
         check("running overload", n_ol, 0);
         check("open path dc", dc_open_cnt, 16'h0);
         rd_reg(dc_brake_pkg::OFS_IRQ_STAT, d);
         check("status", d, 32'h3);
         check("irq", irq, 1'b1);
         wr_reg(dc_brake_pkg::OFS_IRQ_STAT, 32'h7);
         repeat (2) @(posedge ref_clk); #1;
         check("irq cleared", irq, 1'b0);
      end
      $display("test std_hold finished");
   endtask

   task automatic input_abort(input logic [31:0] ctrl, input logic bad_en, bad_dis,
                              input int lag, input logic [31:0] exp_stat);
      int n_dc, n_rel, n_xs, n_ol;
      logic [8:0] lvl;
      logic [31:0] d;
      wr_reg(dc_brake_pkg::OFS_CTRL, ctrl);
      en_req <= bad_en;
      dis_req <= bad_dis;
      repeat (3) @(posedge ref_clk);
      run_stop(n_dc, n_rel, n_xs, n_ol, lvl);
      check("refused stop", n_rel, 0);
      en_req <= ~bad_en;
      dis_req <= ~bad_dis;
      repeat (3) @(posedge ref_clk);
      pulse_stop();
      repeat (lag) @(posedge ref_clk);
      en_req <= bad_en;
      dis_req <= bad_dis;
      repeat (3) @(posedge ref_clk); #1;
      check("relay after abort", relay, 1'b0);
      check("dc after abort", dc, 1'b0);
      en_req <= ~bad_en;
      dis_req <= ~bad_dis;
      repeat (12) @(posedge ref_clk); #1;
      check("no resume", relay, 1'b0);
      check("masked irq", irq, 1'b0);
      rd_reg(dc_brake_pkg::OFS_IRQ_STAT, d);
      check("abort status", d, exp_stat);
      wr_reg(dc_brake_pkg::OFS_IRQ_STAT, 32'h7);
   endtask

   task automatic test_enable_abort();
      input_abort(32'hb, 1'b0, 1'b0, 8, 32'h5);
      $display("test enable_abort finished");
   endtask

   task automatic test_disable_abort();
      input_abort(32'hd, 1'b1, 1'b1, 1, 32'h4);
      $display("test disable_abort finished");
   endtask

   task automatic test_heavy();
      int n_dc, n_rel, n_xs, n_ol;
      logic [8:0] lvl;
      logic [31:0] d;
      en_req <= 1'b0;
      dis_req <= 1'b0;
      do_reset(1'b1, 1'b1);
      heavy_strap <= 1'b0;
      rd_reg(dc_brake_pkg::OFS_CFG, d);
      check("straps", d, 32'h3);
      check("overload ctl idle", ol_ctl, 3'b011);
      wr_reg(dc_brake_pkg::OFS_CTRL, 32'h9);
      wr_reg(dc_brake_pkg::OFS_DELAY, 32'h1);
      wr_reg(dc_brake_pkg::OFS_DURATION, 32'h1);
      wr_reg(dc_brake_pkg::OFS_LEVEL, 32'h1f4);
      run_stop(n_dc, n_rel, n_xs, n_ol, lvl);
      check("heavy level clamp", lvl, 9'h190);
      check("heavy open path dc", dc_open_cnt, 16'h0);
      check("extra start pulse", n_xs, 1);
      check("running overload", n_ol, 0);
      rd_reg(dc_brake_pkg::OFS_STARTS, d);
      check("start count", d, 32'h1);
      $display("test heavy finished");
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      stop_cmd = 1'b0;
      heavy_strap = 1'b0;
      hall_strap = 1'b0;
      en_req = 1'b0;
      dis_req = 1'b0;
      req = '0;
      err_count = 0;
      samples_checked = 0;
      do_reset(1'b0, 1'b0);
      test_reset_values();
      test_std_hold();
      test_enable_abort();
      test_disable_abort();
      test_heavy();
      end_of_test();
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      err_count++;
      end_of_test();
   end
endmodule // tb
